// File: sfa_regs.svh
// Bit positions, selector codes and reset values of the synthesizer control words.
`ifndef SFA_REGS_SVH
`define SFA_REGS_SVH
`define SFA_WORD_W 24
`define SFA_SEL_MSB 1
`define SFA_SEL_LSB 0
`define SFA_SEL_REF 2'h0
`define SFA_SEL_DIV 2'h1
`define SFA_SEL_FUNC 2'h2
`define SFA_SEL_INIT 2'h3
`define SFA_CNT_RESET_BIT 2
`define SFA_PD1_BIT 3
`define SFA_POL_BIT 7
`define SFA_HIZ_BIT 8
`define SFA_FL_EN_BIT 9
`define SFA_FL_MODE_BIT 10
`define SFA_TC_MSB 14
`define SFA_TC_LSB 11
`define SFA_PRI_MSB 17
`define SFA_PRI_LSB 15
`define SFA_SEC_MSB 20
`define SFA_SEC_LSB 18
`define SFA_PD2_BIT 21
`define SFA_PRE_MSB 23
`define SFA_PRE_LSB 22
`define SFA_BOOST_BIT 21
`define SFA_WORD_RST 24'h000000
`define SFA_TMR_RST 8'h00
`endif

// File: sfa_pkg.sv
// Types shared by the synthesizer control logic.
package sfa_pkg;
  typedef enum logic [1:0] {
    SFA_WORD_REF = 2'b00,
    SFA_WORD_DIV = 2'b01,
    SFA_WORD_FUNC = 2'b10,
    SFA_WORD_INIT = 2'b11
  } sfa_word_type;
  typedef enum logic {
    SFA_ARM_IDLE = 1'b0,
    SFA_ARM_WAIT_DIV = 1'b1
  } sfa_arm_type;
endpackage : sfa_pkg

// File: sfa_fast_acquire_ctrl.sv
// Serial word intake, rapid-acquire control and initialization pulse logic.
// Contract
// - Rapid-acquire allowed only while enable bit is 1.
// - Mode bit 0 selects mode one, 1 mode two.
// - Active rapid-acquire drives secondary pump current code.
// - Mode one: boost bit written 1 enters, 0 leaves.
// - Mode two: timeout clears stored boost bit itself.
// - Timeout counter runs only in mode two.
// - Four-bit timeout code sets secondary current duration.
// - Divider write with boost starts the timed period.
// - Period end reverts to primary, boost bit cleared.
// - Two three-bit fields hold primary and secondary current.
// - One function bit sets detector polarity.
// - Pump three-state bit high puts pump in hiz.
// - Init word loads function contents plus reset pulse.
// - Reset pulse loads counters, three-states pump, triggers init-word power-down.
// - Init word synchronous power-down triggered by reset pulse.
// - First divider load after init fires pulse again.
// - Chip enable low powers the device down.
// - Latched configuration kept across chip enable cycles.
// - Two low bits route word to its latch.
// - Shift on serial clock rise, latch on enable rise.
`timescale 1ns/1ps
`include "sfa_regs.svh"
module sfa_fast_acquire_ctrl #(
  parameter int TIMEOUT_W = 8,
  parameter logic [16*TIMEOUT_W-1:0] TIMEOUT_TABLE =
    128'h403c3834302c2824201c1814100c0804
) (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Three-wire serial port.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_enable_pin,
  // Chip enable pin.
  input wire logic chip_enable,
  // Phase detector comparison tick and pump event, on sys_clk.
  input wire logic pd_cycle_tick,
  input wire logic pump_event,
  // Pump control.
  output logic [2:0] pump_current_code,
  output logic pump_hiz,
  output logic pump_boost_field,
  output logic rapid_acquire_active,
  // Counter and power control.
  output logic counter_load,
  output logic internal_reset_pulse,
  output logic powered_down,
  // Latched configuration.
  output logic [1:0] prescaler_select,
  output logic detector_polarity,
  output logic [`SFA_WORD_W-1:0] function_control_word,
  output logic [`SFA_WORD_W-1:0] init_control_word,
  output logic [`SFA_WORD_W-1:0] ref_word,
  output logic [`SFA_WORD_W-1:0] divider_word
);

  // Count limit for a timeout code, taken from the table.
  function automatic logic [TIMEOUT_W-1:0] timeout_limit(input logic [3:0] code);
    timeout_limit = TIMEOUT_TABLE[code*TIMEOUT_W +: TIMEOUT_W];
  endfunction : timeout_limit

  // Serial clock domain: the shift register.
  logic [`SFA_WORD_W-1:0] shift_word;

  always_ff @(posedge ser_clk or negedge rstn) begin
    if (!rstn) begin
      shift_word <= `SFA_WORD_RST;
    end else begin
      shift_word <= {shift_word[`SFA_WORD_W-2:0], ser_data};
    end
  end

  // The first serial edge has no earlier sample, so the check starts one edge later.
  ser_shift_a: assert property (@(posedge ser_clk) disable iff (!rstn)
    1'b1 |=> shift_word[0] == $past(ser_data) &&
    shift_word[`SFA_WORD_W-1:1] == $past(shift_word[`SFA_WORD_W-2:0]))
    else $error("serial shift lost a bit");

  // Pin synchronisers.
  logic le_sync1;
  logic le_sync2;
  logic le_prev;
  logic ce_sync1;
  logic ce_sync2;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      le_sync1 <= 1'b0;
      le_sync2 <= 1'b0;
      le_prev <= 1'b0;
      ce_sync1 <= 1'b0;
      ce_sync2 <= 1'b0;
    end else begin
      le_sync1 <= latch_enable_pin;
      le_sync2 <= le_sync1;
      le_prev <= le_sync2;
      ce_sync1 <= chip_enable;
      ce_sync2 <= ce_sync1;
    end
  end

  // The shift register is quiet while the latch enable is high, so the
  // word is read across domains only after the enable edge has settled.
  wire word_taken = le_sync2 & ~le_prev;
  wire [`SFA_WORD_W-1:0] word_in = shift_word;
  wire [1:0] word_sel = word_in[`SFA_SEL_MSB:`SFA_SEL_LSB];
  wire take_ref = word_taken && (word_sel == `SFA_SEL_REF);
  wire take_div = word_taken && (word_sel == `SFA_SEL_DIV);
  wire take_func = word_taken && (word_sel == `SFA_SEL_FUNC);
  wire take_init = word_taken && (word_sel == `SFA_SEL_INIT);

  // Fields of the function contents.
  wire cnt_reset_bit = function_control_word[`SFA_CNT_RESET_BIT];
  wire power_down_bit_one = function_control_word[`SFA_PD1_BIT];
  wire power_down_bit_two = function_control_word[`SFA_PD2_BIT];
  wire pump_hiz_bit = function_control_word[`SFA_HIZ_BIT];
  wire fl_enable = function_control_word[`SFA_FL_EN_BIT];
  wire fl_mode_two = function_control_word[`SFA_FL_MODE_BIT];
  wire [3:0] timeout_code = function_control_word[`SFA_TC_MSB:`SFA_TC_LSB];
  wire [2:0] primary_current_code =
    function_control_word[`SFA_PRI_MSB:`SFA_PRI_LSB];
  wire [2:0] secondary_current_code =
    function_control_word[`SFA_SEC_MSB:`SFA_SEC_LSB];

  // Latches, kept through chip enable cycles.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      function_control_word <= `SFA_WORD_RST;
      init_control_word <= `SFA_WORD_RST;
      ref_word <= `SFA_WORD_RST;
      divider_word <= `SFA_WORD_RST;
    end else begin
      if (take_func || take_init) begin
        function_control_word <= word_in;
      end
      if (take_init) begin
        init_control_word <= word_in;
      end
      if (take_ref) begin
        ref_word <= word_in;
      end
      if (take_div) begin
        divider_word <= word_in;
      end
    end
  end

  // Initialization pulse arming.
  sfa_pkg::sfa_arm_type arm_state;
  sfa_pkg::sfa_arm_type next_arm_state;

  always_comb begin
    next_arm_state = arm_state;
    case (arm_state)
      sfa_pkg::SFA_ARM_IDLE: begin
        if (take_init) begin
          next_arm_state = sfa_pkg::SFA_ARM_WAIT_DIV;
        end
      end
      sfa_pkg::SFA_ARM_WAIT_DIV: begin
        if (take_div) begin
          next_arm_state = sfa_pkg::SFA_ARM_IDLE;
        end
      end
      default: begin
        next_arm_state = sfa_pkg::SFA_ARM_IDLE;
      end
    endcase
  end

  wire fire_pulse = take_init ||
    (take_div && (arm_state == sfa_pkg::SFA_ARM_WAIT_DIV));

  // Rapid-acquire boost and timeout counter.
  logic boost_bit;
  logic [TIMEOUT_W-1:0] tmr_count;
  wire fl_active = fl_enable & boost_bit;
  wire tmr_run = fl_active & fl_mode_two;
  wire [TIMEOUT_W-1:0] tmr_inc = tmr_count + {{(TIMEOUT_W-1){1'b0}}, 1'b1};
  wire tmr_expire = tmr_run && pd_cycle_tick &&
    (tmr_inc >= timeout_limit(timeout_code));
  wire tmr_clear = counter_load || !tmr_run || take_div || tmr_expire;
  wire sync_pd_init = ce_sync2 & power_down_bit_one & ~power_down_bit_two;
  wire sync_pd_pump = power_down_bit_one & power_down_bit_two & pump_event;
  logic pd_hold;

  // A divider load in the expiry cycle wins, so a new boost is not lost.
  wire next_boost = take_div ? word_in[`SFA_BOOST_BIT] :
    (tmr_expire ? 1'b0 : boost_bit);
  wire [TIMEOUT_W-1:0] next_tmr = tmr_clear ? `SFA_TMR_RST :
    (pd_cycle_tick ? tmr_inc : tmr_count);
  wire next_pd_hold = (internal_reset_pulse && sync_pd_init) || sync_pd_pump ?
    1'b1 : (power_down_bit_one ? pd_hold : 1'b0);
  wire next_powered_down = ~ce_sync2 | pd_hold;
  wire next_counter_load = fire_pulse | cnt_reset_bit | next_powered_down;
  wire next_hiz = pump_hiz_bit | next_counter_load;
  wire [2:0] next_code = fl_active ? secondary_current_code :
    primary_current_code;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arm_state <= sfa_pkg::SFA_ARM_IDLE;
      boost_bit <= 1'b0;
      tmr_count <= `SFA_TMR_RST;
      pd_hold <= 1'b0;
    end else begin
      arm_state <= next_arm_state;
      boost_bit <= next_boost;
      tmr_count <= next_tmr;
      pd_hold <= next_pd_hold;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      internal_reset_pulse <= 1'b0;
      powered_down <= 1'b1;
      counter_load <= 1'b1;
      pump_hiz <= 1'b1;
      pump_current_code <= 3'h0;
    end else begin
      internal_reset_pulse <= fire_pulse;
      powered_down <= next_powered_down;
      counter_load <= next_counter_load;
      pump_hiz <= next_hiz;
      pump_current_code <= next_code;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pump_boost_field <= 1'b0;
      rapid_acquire_active <= 1'b0;
      prescaler_select <= 2'h0;
      detector_polarity <= 1'b0;
    end else begin
      pump_boost_field <= next_boost;
      rapid_acquire_active <= fl_enable & next_boost;
      prescaler_select <= function_control_word[`SFA_PRE_MSB:`SFA_PRE_LSB];
      detector_polarity <= function_control_word[`SFA_POL_BIT];
    end
  end

  // Checks on the system clock domain.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence init_taken_s;
    take_init;
  endsequence

  sequence first_div_s;
    take_div && arm_state == sfa_pkg::SFA_ARM_WAIT_DIV;
  endsequence

  fl_gate_a: assert property (!fl_enable |=> !rapid_acquire_active)
    else $error("rapid-acquire active while disabled");

  sec_current_a: assert property (fl_active && !take_div && !tmr_expire
    |=> pump_current_code == $past(secondary_current_code))
    else $error("secondary current not applied");

  pri_current_a: assert property (!fl_active |=>
    pump_current_code == $past(primary_current_code))
    else $error("primary current not applied");

  mode_one_hold_a: assert property (boost_bit && !fl_mode_two && !take_div
    |=> boost_bit)
    else $error("mode one boost dropped without write");

  boost_write_a: assert property (take_div |=>
    boost_bit == $past(word_in[`SFA_BOOST_BIT]))
    else $error("boost bit not taken from divider word");

  timeout_clear_a: assert property (tmr_expire && !take_div |=> !boost_bit)
    else $error("boost bit not cleared at timeout");

  tmr_idle_a: assert property (!fl_mode_two |=> tmr_count == `SFA_TMR_RST)
    else $error("timeout counter ran outside mode two");

  tmr_limit_a: assert property (tmr_run && pd_cycle_tick && !counter_load &&
    !take_div && tmr_inc == timeout_limit(timeout_code) |=> !boost_bit)
    else $error("timeout limit missed");

  hiz_bit_a: assert property (pump_hiz_bit |=> pump_hiz)
    else $error("pump not three-stated by hiz bit");

  init_load_a: assert property (init_taken_s |=> internal_reset_pulse &&
    function_control_word == $past(word_in))
    else $error("init word did not load and pulse");

  pulse_effect_a: assert property (internal_reset_pulse |->
    counter_load && pump_hiz)
    else $error("reset pulse did not load counters");

  sync_pd_a: assert property (internal_reset_pulse && sync_pd_init
    |=> pd_hold ##1 powered_down)
    else $error("synchronous power-down not triggered");

  first_div_a: assert property (first_div_s |=> internal_reset_pulse)
    else $error("first divider load did not pulse");

  later_div_a: assert property (take_div &&
    arm_state == sfa_pkg::SFA_ARM_IDLE |=> !internal_reset_pulse)
    else $error("later divider load pulsed");

  ce_down_a: assert property (!ce_sync2 |=> powered_down && pump_hiz)
    else $error("chip enable low did not power down");

  retain_a: assert property (!word_taken |=>
    $stable(function_control_word) && $stable(divider_word))
    else $error("latched configuration changed without a word");

  route_ref_a: assert property (take_ref |=>
    ref_word == $past(word_in) && $stable(divider_word))
    else $error("reference word misrouted");

  // Counter load, timer, routing, polarity, pulse and power-down checks.
  route_div_a: assert property (take_div |=>
    divider_word == $past(word_in) && $stable(ref_word))
    else $error("divider word misrouted");

  route_init_a: assert property (take_init |=>
    init_control_word == $past(word_in))
    else $error("init word misrouted");

  cnt_reset_a: assert property (cnt_reset_bit |=>
    counter_load && pump_hiz)
    else $error("counter reset bit did not hold counters");

  pd_hiz_a: assert property (powered_down |->
    counter_load && pump_hiz)
    else $error("power-down did not load counters");

  tmr_div_clear_a: assert property (take_div |=>
    tmr_count == `SFA_TMR_RST)
    else $error("divider load did not restart timer");

  tmr_load_clear_a: assert property (counter_load |=>
    tmr_count == `SFA_TMR_RST)
    else $error("timer not held at load state");

  tmr_step_a: assert property (tmr_run && pd_cycle_tick && !tmr_clear |=>
    tmr_count == $past(tmr_inc))
    else $error("timer did not advance on tick");

  tmr_hold_a: assert property (!pd_cycle_tick && !tmr_clear |=>
    $stable(tmr_count))
    else $error("timer moved without a tick");

  polarity_a: assert property (1'b1 |=>
    detector_polarity == $past(function_control_word[`SFA_POL_BIT]))
    else $error("detector polarity not applied");

  pulse_once_a: assert property (internal_reset_pulse |=>
    !internal_reset_pulse)
    else $error("reset pulse longer than one cycle");

  pump_pd_a: assert property (sync_pd_pump |=>
    pd_hold)
    else $error("pump event did not power down");

  ce_up_a: assert property (ce_sync2 && !pd_hold |=>
    !powered_down)
    else $error("device stayed down with chip enable high");

endmodule : sfa_fast_acquire_ctrl

// File: sfa_ser_host.sv
// Serial host model that writes 24-bit control words over the three-wire port.
`timescale 1ns/1ps
module sfa_ser_host (
  // Three-wire serial port.
  output logic ser_clk,
  output logic ser_data,
  output logic latch_enable_pin
);
  initial begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    latch_enable_pin = 1'h0;
  end
  // The clock stands still between words and released data shows its inverse.
  task automatic send(input logic [23:0] word);
    #7;
    for (int i = 23; i >= 0; i--) begin
      ser_data = word[i];
      #24 ser_clk = 1'h1;
      #24 ser_clk = 1'h0;
    end
    ser_data = ~word[0];
    #24 latch_enable_pin = 1'h1;
    #200 latch_enable_pin = 1'h0;
    #200;
  endtask : send
endmodule : sfa_ser_host

// File: sfa_fast_acquire_ctrl_test.sv
// Self-checking bench for the rapid-acquire and initialization control.
`timescale 1ns/1ps
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin bad_count++; \
  $display("FAIL %0t got %h expected %h", $time, act, exp); end end
module sfa_fast_acquire_ctrl_test;
  localparam logic [2:0] PRI = 3'h5;
  localparam logic [2:0] SEC = 3'h3;
  // Timeout code 1 gives 4*(1+1) ticks with the default table.
  localparam int TICKS = 8;
  logic sys_clk, rstn, chip_enable, pd_cycle_tick, pump_event;
  wire ser_clk, ser_data, latch_enable_pin;
  logic [2:0] pump_current_code;
  logic pump_hiz, pump_boost_field, rapid_acquire_active, counter_load;
  logic internal_reset_pulse, powered_down, detector_polarity;
  logic [1:0] prescaler_select;
  logic [23:0] function_control_word, init_control_word, ref_word, divider_word;
  int bad_count, num_checks, pulses;

  sfa_ser_host host (.ser_clk, .ser_data, .latch_enable_pin);
  sfa_fast_acquire_ctrl uut (.sys_clk, .rstn, .ser_clk, .ser_data, .latch_enable_pin,
    .chip_enable, .pd_cycle_tick, .pump_event, .pump_current_code, .pump_hiz,
    .pump_boost_field, .rapid_acquire_active, .counter_load, .internal_reset_pulse,
    .powered_down, .prescaler_select, .detector_polarity, .function_control_word,
    .init_control_word, .ref_word, .divider_word);

  // Flag bits are mode, enable, three-state, power-down one, power-down two.
  function automatic logic [23:0] fw(input logic [1:0] sel, input logic [4:0] f);
    return {2'h2, f[0], SEC, PRI, 4'h1, f[4:2], 1'h1, 3'h0, f[1], 1'h0, sel};
  endfunction : fw
  function automatic logic [23:0] dw(input logic boost);
    return {2'h0, boost, 19'h01234, 2'h1};
  endfunction : dw

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_n
  task automatic send(input logic [23:0] w);
    host.send(w);
    wait_n(1);
  endtask : send
  task automatic tick(input int n);
    repeat (n) begin
      pd_cycle_tick = 1'h1;
      wait_n(1);
      pd_cycle_tick = 1'h0;
      wait_n(1);
    end
  endtask : tick

  always @(posedge sys_clk) begin
    if (internal_reset_pulse === 1'h1) begin
      pulses++;
      `CHK(counter_load & pump_hiz, 1'h1)
    end
  end

  task automatic t_init;
    send(fw(2'h3, 5'h18));
    `CHK(init_control_word, fw(2'h3, 5'h18))
    `CHK(function_control_word, fw(2'h3, 5'h18))
    `CHK(pulses, 1)
    `CHK(detector_polarity, 1'h1)
    `CHK(prescaler_select, 2'h2)
    send(fw(2'h2, 5'h18));
    send(24'h000100);
    `CHK(ref_word, 24'h000100)
    `CHK(pulses, 1)
    send(dw(1'h0));
    `CHK(pulses, 2)
    `CHK(divider_word, dw(1'h0))
    send(dw(1'h0));
    `CHK(pulses, 2)
    `CHK(pump_current_code, PRI)
    `CHK(pump_hiz, 1'h0)
    $display("t_init done");
  endtask : t_init

  task automatic t_mode2;
    send(dw(1'h1));
    `CHK(pump_current_code, SEC)
    `CHK(rapid_acquire_active, 1'h1)
    tick(TICKS - 1);
    wait_n(3);
    `CHK(pump_current_code, SEC)
    tick(1);
    wait_n(3);
    `CHK(pump_boost_field, 1'h0)
    `CHK(pump_current_code, PRI)
    send(dw(1'h1));
    `CHK(pump_current_code, SEC)
    tick(TICKS);
    wait_n(3);
    `CHK(rapid_acquire_active, 1'h0)
    $display("t_mode2 done");
  endtask : t_mode2

  task automatic t_mode1;
    send(fw(2'h2, 5'h08));
    send(dw(1'h1));
    tick(2 * TICKS);
    wait_n(3);
    `CHK(pump_current_code, SEC)
    send(dw(1'h0));
    `CHK(pump_current_code, PRI)
    `CHK(rapid_acquire_active, 1'h0)
    $display("t_mode1 done");
  endtask : t_mode1

  task automatic t_off;
    send(fw(2'h2, 5'h14));
    send(dw(1'h1));
    `CHK(rapid_acquire_active, 1'h0)
    `CHK(pump_current_code, PRI)
    `CHK(pump_hiz, 1'h1)
    send(dw(1'h0));
    $display("t_off done");
  endtask : t_off

  task automatic t_sync_pd;
    send(fw(2'h3, 5'h0a));
    `CHK(powered_down, 1'h1)
    send(fw(2'h2, 5'h08));
    `CHK(powered_down, 1'h0)
    send(fw(2'h2, 5'h08) | 24'h000004);
    `CHK(counter_load & pump_hiz, 1'h1)
    send(fw(2'h2, 5'h0b));
    `CHK(powered_down, 1'h0)
    pump_event = 1'h1;
    wait_n(1);
    pump_event = 1'h0;
    wait_n(3);
    `CHK(powered_down, 1'h1)
    send(fw(2'h2, 5'h08));
    wait_n(2);
    `CHK(powered_down, 1'h0)
    `CHK(counter_load, 1'h0)
    $display("t_sync_pd done");
  endtask : t_sync_pd

  task automatic t_ce;
    chip_enable = 1'h0;
    wait_n(4);
    `CHK(powered_down, 1'h1)
    `CHK(pump_hiz, 1'h1)
    send(fw(2'h2, 5'h18));
    send(24'h000200);
    send(dw(1'h0));
    `CHK(powered_down, 1'h1)
    chip_enable = 1'h1;
    wait_n(5);
    `CHK(powered_down, 1'h0)
    `CHK(function_control_word, fw(2'h2, 5'h18))
    `CHK(ref_word, 24'h000200)
    $display("t_ce done");
  endtask : t_ce

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #3000000;
    bad_count++;
    $display("FAIL %0t run did not finish", $time);
    complete_run();
  end
  initial begin
    rstn = 1'h0;
    chip_enable = 1'h1;
    pd_cycle_tick = 1'h0;
    pump_event = 1'h0;
    bad_count = 0;
    num_checks = 0;
    pulses = 0;
    wait_n(8);
    rstn = 1'h1;
    wait_n(4);
    t_init();
    t_mode2();
    t_mode1();
    t_off();
    t_sync_pd();
    t_ce();
    complete_run();
  end
endmodule : sfa_fast_acquire_ctrl_test
